// *** hdl/sfpms_pkg.sv ***
// Constants and types for the module management and status block
package sfpms_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int SCL_MAX_KHZ = 400;
  localparam int T_INIT_MS = 300;
  localparam int T_OFF_US = 10;
  localparam int T_FAULT_US = 100;
  localparam int INIT_CYCLES = T_INIT_MS * (CLK_HZ / 1000);
  localparam int OFF_CYCLES = T_OFF_US * (CLK_HZ / 1_000_000);
  localparam int FAULT_CYCLES = T_FAULT_US * (CLK_HZ / 1_000_000);
  localparam int REFRESH_CYCLES = 2000;
  localparam int SYNC_STAGES = 3;
  // Two-wire device addresses (7 bit)
  localparam logic [6:0] ID_DEV_ADDR = 7'h50;
  localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;
  // Diagnostic page byte offsets
  localparam logic [7:0] DIAG_MON_BASE = 8'h00;
  localparam logic [7:0] DIAG_STATUS_OFS = 8'h0a;
  localparam logic [7:0] DIAG_CALMODE_OFS = 8'h0b;
  localparam logic [7:0] DIAG_SLOPE_OFS = 8'h0c;
  localparam logic [7:0] DIAG_OFFSET_OFS = 8'h0e;
  localparam int ID_ROM_DEPTH = 16;
  // Reset values
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [15:0] CAL_SLOPE_DEF = 16'h0100;
  localparam logic [15:0] CAL_OFFSET_DEF = 16'h0000;
  localparam int MON_COUNT = 5;
  localparam int MON_W = 16;

  typedef struct packed {
    logic [15:0] temperature;
    logic [15:0] supply;
    logic [15:0] bias;
    logic [15:0] tx_power;
    logic [15:0] rx_power;
  } sfpms_mon_t;

  typedef struct packed {
    logic tx_fault;
    logic signal_absent;
    logic presence;
  } sfpms_pins_t;

  typedef enum logic [2:0] {
    SFPMS_IDLE = 3'b000,
    SFPMS_RX = 3'b001,
    SFPMS_RX_ACK = 3'b010,
    SFPMS_TX = 3'b011,
    SFPMS_TX_ACK = 3'b100
  } sfpms_state_t;

  typedef enum logic [1:0] {
    SFPMS_K_DEV = 2'b00,
    SFPMS_K_WORD = 2'b01,
    SFPMS_K_DATA = 2'b10
  } sfpms_kind_t;
endpackage

// *** hdl/sfpms_top.sv ***
// Module management and status: two-wire memory, diagnostics and pin status
module sfpms_top #(
  parameter int INIT_CYC = sfpms_pkg::INIT_CYCLES,
  parameter int REFRESH_CYC = sfpms_pkg::REFRESH_CYCLES,
  parameter logic [15:0] CAL_SLOPE = sfpms_pkg::CAL_SLOPE_DEF,
  parameter logic [15:0] CAL_OFFSET = sfpms_pkg::CAL_OFFSET_DEF,
  parameter logic [7:0] ID_BYTE_BASE = 8'h5a  // Arbitrary identity seed
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Two-wire pins from the host
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Host control pin
  input wire logic transmitter_off_input,
  input wire logic transmitter_off_input_open,
  // Internal sensors
  input wire logic laser_fault,
  input wire logic rx_light_lost,
  input wire logic cal_external,
  input wire sfpms_pkg::sfpms_mon_t mon_raw,
  // Status pins and laser control
  output sfpms_pkg::sfpms_pins_t pins,
  output logic laser_enable,
  output logic init_done
);
  import sfpms_pkg::*;

  // Elaboration checks: refresh counter is 16 bits wide
  if (INIT_CYC < 1 || INIT_CYC > INIT_CYCLES) begin
    $error("INIT_CYC out of range");
  end
  if (REFRESH_CYC < 1 || REFRESH_CYC > 2 ** 16) begin
    $error("REFRESH_CYC out of range");
  end

  // Pin synchronisers
  localparam int NSYNC = 3;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_r, s2_r, s3_r, stable_r;
  assign raw_in = {transmitter_off_input | transmitter_off_input_open, sda_in, scl_in};

  always_ff @(posedge clock) begin
    if (rst) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      stable_r <= '1;
    end else begin
      s1_r <= raw_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < NSYNC; i++) begin
        if (s2_r[i] == s3_r[i]) stable_r[i] <= s3_r[i];
      end
    end
  end

  logic scl_f, sda_f, txoff_f;
  logic scl_q_r, sda_q_r;
  assign scl_f = stable_r[0];
  assign sda_f = stable_r[1];
  assign txoff_f = stable_r[2];

  always_ff @(posedge clock) begin
    if (rst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_f & ~scl_q_r;
  assign scl_fall = ~scl_f & scl_q_r;
  assign bus_start = scl_f & scl_q_r & sda_q_r & ~sda_f;
  assign bus_stop = scl_f & scl_q_r & ~sda_q_r & sda_f;

  // Power-up initialization
  logic [31:0] init_cnt_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      init_cnt_r <= '0;
      init_done <= 1'b0;
    end else if (!init_done) begin
      if (init_cnt_r == 32'(INIT_CYC - 1)) init_done <= 1'b1;
      else init_cnt_r <= init_cnt_r + 32'd1;
    end
  end

  // Status pins and laser shutdown
  always_ff @(posedge clock) begin
    if (rst) begin
      pins <= '{tx_fault: 1'b1, signal_absent: 1'b1, presence: 1'b0};
      laser_enable <= 1'b0;
    end else begin
      pins.tx_fault <= ~init_done | laser_fault;
      pins.signal_absent <= rx_light_lost;
      pins.presence <= 1'b0;
      laser_enable <= init_done & ~txoff_f;
    end
  end

  // Monitor snapshot, frozen while a transfer is in progress
  sfpms_state_t state_r;
  logic [15:0] refresh_cnt_r;
  logic [MON_COUNT-1:0][MON_W-1:0] raw_v, snap_raw_r, snap_cal_r;
  assign raw_v = mon_raw;

  always_ff @(posedge clock) begin
    if (rst) begin
      refresh_cnt_r <= '0;
      snap_raw_r <= '0;
      snap_cal_r <= '0;
    end else if (refresh_cnt_r >= 16'(REFRESH_CYC - 1)) begin
      if (state_r == SFPMS_IDLE) begin
        refresh_cnt_r <= '0;
        for (int m = 0; m < MON_COUNT; m++) begin
          snap_raw_r[m] <= raw_v[m];
          snap_cal_r[m] <= 16'((32'(raw_v[m]) * 32'(CAL_SLOPE)) >> 8) + CAL_OFFSET;
        end
      end
    end else begin
      refresh_cnt_r <= refresh_cnt_r + 16'd1;
    end
  end

  // Readable memory
  logic [7:0] id_rom [ID_ROM_DEPTH];
  always_comb begin
    for (int b = 0; b < ID_ROM_DEPTH; b++) id_rom[b] = ID_BYTE_BASE + 8'(b);
  end

  logic diag_page_r;
  logic [7:0] ptr_r;
  logic [7:0] rd_byte;
  logic [MON_W-1:0] mon_sel;
  logic [3:0] mon_idx;

  always_comb begin
    mon_idx = ptr_r[4:1];
    mon_sel = '0;
    if (mon_idx < 4'(MON_COUNT)) begin
      mon_sel = cal_external ? snap_raw_r[MON_COUNT-1-mon_idx] : snap_cal_r[MON_COUNT-1-mon_idx];
    end
    rd_byte = 8'h00;
    if (!diag_page_r) begin
      if (ptr_r < 8'(ID_ROM_DEPTH)) rd_byte = id_rom[ptr_r[3:0]];
    end else if (ptr_r < DIAG_STATUS_OFS) begin
      rd_byte = ptr_r[0] ? mon_sel[7:0] : mon_sel[15:8];
    end else begin
      case (ptr_r)
        DIAG_STATUS_OFS: rd_byte = {5'h00, txoff_f, pins.tx_fault, pins.signal_absent};
        DIAG_CALMODE_OFS: rd_byte = {7'h00, cal_external};
        DIAG_SLOPE_OFS: rd_byte = CAL_SLOPE[15:8];
        DIAG_SLOPE_OFS + 8'h01: rd_byte = CAL_SLOPE[7:0];
        DIAG_OFFSET_OFS: rd_byte = CAL_OFFSET[15:8];
        DIAG_OFFSET_OFS + 8'h01: rd_byte = CAL_OFFSET[7:0];
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Two-wire slave
  sfpms_kind_t kind_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_sh_r;
  logic rw_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= SFPMS_IDLE;
      kind_r <= SFPMS_K_DEV;
      bit_cnt_r <= '0;
      shift_r <= '0;
      tx_sh_r <= '0;
      rw_r <= 1'b0;
      diag_page_r <= 1'b0;
      ptr_r <= PTR_RESET;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      state_r <= SFPMS_RX;
      kind_r <= SFPMS_K_DEV;
      bit_cnt_r <= '0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      state_r <= SFPMS_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state_r)
        SFPMS_IDLE: sda_oe <= 1'b0;
        SFPMS_RX: begin
          if (scl_rise && bit_cnt_r < 4'd8) begin
            shift_r <= {shift_r[6:0], sda_f};
            bit_cnt_r <= bit_cnt_r + 4'd1;
          end else if (scl_fall && bit_cnt_r == 4'd8) begin
            if (kind_r == SFPMS_K_DEV) begin
              if (shift_r[7:1] == ID_DEV_ADDR || shift_r[7:1] == DIAG_DEV_ADDR) begin
                diag_page_r <= shift_r[1];
                rw_r <= shift_r[0];
                sda_oe <= 1'b1;
                state_r <= SFPMS_RX_ACK;
              end else begin
                state_r <= SFPMS_IDLE;
              end
            end else begin
              if (kind_r == SFPMS_K_WORD) ptr_r <= shift_r;
              sda_oe <= 1'b1;
              state_r <= SFPMS_RX_ACK;
            end
          end
        end
        SFPMS_RX_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= '0;
            if (kind_r == SFPMS_K_DEV && rw_r) begin
              tx_sh_r <= rd_byte;
              sda_oe <= ~rd_byte[7];
              ptr_r <= ptr_r + 8'd1;
              bit_cnt_r <= 4'd1;
              state_r <= SFPMS_TX;
            end else begin
              sda_oe <= 1'b0;
              kind_r <= (kind_r == SFPMS_K_DEV) ? SFPMS_K_WORD : SFPMS_K_DATA;
              state_r <= SFPMS_RX;
            end
          end
        end
        SFPMS_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == 4'd8) begin
              sda_oe <= 1'b0;
              state_r <= SFPMS_TX_ACK;
            end else begin
              sda_oe <= ~tx_sh_r[6];
              tx_sh_r <= {tx_sh_r[6:0], 1'b0};
              bit_cnt_r <= bit_cnt_r + 4'd1;
            end
          end
        end
        SFPMS_TX_ACK: begin
          if (scl_rise && sda_f) begin
            state_r <= SFPMS_IDLE;
          end else if (scl_fall) begin
            tx_sh_r <= rd_byte;
            sda_oe <= ~rd_byte[7];
            ptr_r <= ptr_r + 8'd1;
            bit_cnt_r <= 4'd1;
            state_r <= SFPMS_TX;
          end
        end
        default: begin
          state_r <= SFPMS_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule

// *** tb/sfpms_top_sva.sv ***
// Port assertions for the management and status block
module sfpms_top_sva
  import sfpms_pkg::*;
#(
  parameter int INIT_CYC = sfpms_pkg::INIT_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Two-wire and control pins
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic transmitter_off_input,
  input wire logic transmitter_off_input_open,
  input wire logic laser_fault,
  input wire logic rx_light_lost,
  // Status
  input wire sfpms_pkg::sfpms_pins_t pins,
  input wire logic laser_enable,
  input wire logic init_done
);
  int cnt_r;
  logic off;
  assign off = transmitter_off_input | transmitter_off_input_open;
  // Cycles since reset release, saturating
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_r <= 0;
    end else if (cnt_r < INIT_CYC + 4) begin
      cnt_r <= cnt_r + 1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_off; off [*8]; endsequence
  sequence s_on; (!off && init_done) [*8]; endsequence
  property p_presence; !pins.presence; endproperty
  property p_open_drain; !sda_out; endproperty
  property p_fault_on; $rose(laser_fault) |=> pins.tx_fault; endproperty
  property p_fault_off;
    init_done && $past(init_done) && !$past(laser_fault) |-> !pins.tx_fault;
  endproperty
  property p_los; !$past(rst) |-> pins.signal_absent == $past(rx_light_lost); endproperty
  property p_off; s_off |-> !laser_enable; endproperty
  property p_on; s_on |-> laser_enable; endproperty
  property p_init_lo; init_done |-> cnt_r >= INIT_CYC - 2; endproperty
  property p_init_hi; cnt_r >= INIT_CYC + 2 |-> init_done; endproperty
  property p_oe_edge; $changed(sda_oe) |-> !scl_in && !$past(scl_in, 3); endproperty
  a_presence: assert property (p_presence) else $error("presence high");
  a_open_drain: assert property (p_open_drain) else $error("sda_out high");
  a_fault_on: assert property (p_fault_on) else $error("fault late");
  a_fault_off: assert property (p_fault_off) else $error("fault stuck");
  a_los: assert property (p_los) else $error("signal_absent wrong");
  a_off: assert property (p_off) else $error("laser on");
  a_on: assert property (p_on) else $error("laser off");
  a_init_lo: assert property (p_init_lo) else $error("init early");
  a_init_hi: assert property (p_init_hi) else $error("init late");
  a_oe_edge: assert property (p_oe_edge) else $error("sda_oe moved");
endmodule

bind sfpms_top sfpms_top_sva #(.INIT_CYC(INIT_CYC)) i_sva (.clock(clock), .rst(rst),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .transmitter_off_input(transmitter_off_input),
  .transmitter_off_input_open(transmitter_off_input_open), .laser_fault(laser_fault),
  .rx_light_lost(rx_light_lost), .pins(pins), .laser_enable(laser_enable),
  .init_done(init_done));

// *** tb/sfpms_host.sv ***
// Host board model: two-wire master just under 400 kHz
module sfpms_host (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 650; // Quarter of a 2.6 us bit, a whole number of clocks
  logic smp;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Four quarter phases of {sda_low, scl}; data sampled mid-high
  task automatic ph(input logic [7:0] p);
    for (int i = 3; i >= 0; i--) begin
      if (i == 1) smp = sda;
      {sda_low, scl} = p[2*i+:2];
      #Q;
    end
  endtask
  task automatic wbit(input logic b);
    ph({~b, 1'b0, ~b, 1'b1, ~b, 1'b1, ~b, 1'b0});
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      wbit(v[i]);
    end
    ph(8'h14);
    ack = ~smp;
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, input int n,
                    output logic [15:0] d, output logic ack);
    logic a;
    d = 16'h0000;
    ph({1'b0, scl, 6'h1e});
    wbyte({dev, 1'b0}, ack);
    if (ack) begin
      wbyte(ptr, a);
      ack = ack & a;
      ph({1'b0, scl, 6'h1e});
      wbyte({dev, 1'b1}, a);
      ack = ack & a;
      for (int k = 0; k < n * 8; k++) begin
        ph(8'h14);
        d = {d[14:0], smp};
        if (k % 8 == 7) wbit(k == n * 8 - 1); // Last byte is refused with NACK
      end
    end
    ph(8'hb5);
  endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the management and status block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sfpms_pkg::*;
  localparam int INIT = 20;
  localparam logic [15:0] SLOPE = 16'h0200;
  localparam logic [15:0] OFS = 16'h0010;
  localparam logic [7:0] ID_BASE = 8'h3c; // Arbitrary identity value
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_low, sda, sda_out, sda_oe, tx_off, tx_open, fault, lost, cal_ext, laser_en, done;
  logic [15:0] d;
  logic a;
  sfpms_mon_t mon;
  sfpms_pins_t pins;
  int err_count = 0;
  int check_count = 0;
  always #25 clock = ~clock;
  assign sda = ~(sda_oe | sda_low); // Pull-up on the data line
  sfpms_top #(.INIT_CYC(INIT), .REFRESH_CYC(8), .CAL_SLOPE(SLOPE), .CAL_OFFSET(OFS),
    .ID_BYTE_BASE(ID_BASE)) i_dut (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .transmitter_off_input(tx_off),
    .transmitter_off_input_open(tx_open), .laser_fault(fault), .rx_light_lost(lost),
    .cal_external(cal_ext), .mon_raw(mon), .pins(pins), .laser_enable(laser_en),
    .init_done(done));
  sfpms_host i_host (.scl(scl), .sda_low(sda_low), .sda(sda));
  task automatic chk_bit(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %b, seen %b", n, e, g);
    end
  endtask
  task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic rd_chk(string nm, logic [6:0] dv, logic [7:0] p, int n, logic [15:0] e);
    i_host.rd(dv, p, n, d, a);
    chk_bit(nm, 1'b1, a);
    chk_word(nm, e, d);
  endtask
  task automatic t_reset();
    chk_bit("tx_fault", 1'b1, pins.tx_fault);
    chk_bit("presence", 1'b0, pins.presence);
    chk_bit("laser_enable", 1'b0, laser_en);
    cyc(INIT + 3);
    chk_bit("init_done", 1'b1, done);
    chk_bit("tx_fault", 1'b0, pins.tx_fault);
    chk_bit("laser_enable", 1'b1, laser_en);
    $display("test reset done");
  endtask
  task automatic t_fault();
    fault = 1'b1;
    cyc(2);
    chk_bit("tx_fault", 1'b1, pins.tx_fault);
    fault = 1'b0;
    cyc(2);
    chk_bit("tx_fault", 1'b0, pins.tx_fault);
    $display("test fault done");
  endtask
  task automatic t_txoff();
    for (int i = 0; i < 2; i++) begin
      {tx_open, tx_off} = 2'h1 << i; // Driven high, then left open
      cyc(8);
      chk_bit("laser_enable", 1'b0, laser_en);
      {tx_open, tx_off} = 2'h0;
      cyc(8);
      chk_bit("laser_enable", 1'b1, laser_en);
    end
    $display("test txoff done");
  endtask
  task automatic t_los();
    lost = 1'b1;
    cyc(2);
    chk_bit("signal_absent", 1'b1, pins.signal_absent);
    rd_chk("status", 7'h51, 8'h0a, 1, 16'h0001);
    cyc(1);
    lost = 1'b0;
    cyc(2);
    chk_bit("signal_absent", 1'b0, pins.signal_absent);
    $display("test los done");
  endtask
  task automatic t_id();
    rd_chk("id byte", 7'h50, 8'h03, 1, {8'h00, ID_BASE + 8'h03});
    rd_chk("id blank", 7'h50, 8'h10, 1, 16'h0000);
    i_host.rd(7'h30, 8'h00, 1, d, a);
    chk_bit("foreign ack", 1'b0, a);
    $display("test id done");
  endtask
  task automatic t_diag();
    mon = {16'h1234, 16'h8001, 16'h00ff, 16'h4000, 16'hfffe};
    cal_ext = 1'b1;
    cyc(20);
    rd_chk("raw temp", 7'h51, 8'h00, 2, 16'h1234);
    rd_chk("raw rx", 7'h51, 8'h08, 2, 16'hfffe);
    rd_chk("cal mode", 7'h51, 8'h0b, 1, 16'h0001);
    rd_chk("slope", 7'h51, 8'h0c, 2, SLOPE);
    rd_chk("offset", 7'h51, 8'h0e, 2, OFS);
    // Monitor moves in mid-transfer; the read must keep the old sample
    fork
      begin
        cyc(1000);
        mon.temperature = 16'h5678;
      end
    join_none
    rd_chk("frozen temp", 7'h51, 8'h00, 2, 16'h1234);
    cyc(1);
    cal_ext = 1'b0;
    mon.bias = 16'h0345;
    cyc(20);
    rd_chk("cal bias", 7'h51, 8'h04, 2, 16'(32'h0345 * SLOPE >> 8) + OFS);
    $display("test diag done");
  endtask
  initial begin
    {tx_off, tx_open, fault, lost, cal_ext} = 5'h00;
    mon = 80'h0;
    cyc(2);
    rst = 1'b0;
    t_reset();
    t_fault();
    t_txoff();
    t_los();
    t_id();
    t_diag();
    end_of_test();
  end
  // About two and a half times the expected run of some dozen transfers
  initial begin
    #3ms;
    err_count++;
    end_of_test();
  end
endmodule
